//--- logic/isf_top.sv
// Purpose: status-flag logic of a master/slave i2c controller
// Assumes: apb slave on pclk; scl/sda are pins, sampled by pclk
// Notes:   simplified byte engine drives the flags
//
// Functional notes
// - master transmit: ack status takes the slave's ack bit at slot end
// - tx progress set at transmit start, cleared at end of slave ack
// - bus collision during master operation sets a flag held until cleared
// - general call seen set on general call match, cleared at stop
// - ten-bit match set on second matching address byte, cleared at stop
// - write to tx holding while busy is dropped and flags write collision
// - receive overflow set when moving a byte into a full holding register
// - data/address cleared on address match, set on slave data byte
// - stop seen updated on each start, repeated start or stop
// - unimplemented status bits 13 to 11 and 2 read as zero
`timescale 1ns/1ps
module isf_top (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // i2c pins
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // interrupt
  output logic             irq
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_MADDR = 3'b001,
    ST_MACK  = 3'b010,
    ST_SRX   = 3'b011,
    ST_SACK  = 3'b100,
    ST_SKIP  = 3'b101
  } isf_state_t;

  localparam int NUM_EV_W = isf_pkg::NUM_EV;

  isf_state_t  state;
  logic        scl_s;
  logic        sda_s;
  logic        start_det;
  logic        stop_det;
  logic        scl_rise;
  logic        scl_fall;
  logic [7:0]  shreg;
  logic [3:0]  bitcnt;
  logic        first_byte;
  logic        ten_pend;
  logic        own_match;
  logic [7:0]  tx_holding_reg;
  logic        tx_full;
  logic [7:0]  rx_holding_reg;
  logic        rx_full;
  logic [7:0]  rx_shift_reg;
  logic        ack_status;
  logic        tx_in_progress;
  logic        bus_collision;
  logic        general_call_seen;
  logic        ten_bit_match;
  logic        write_collision;
  logic        rx_overflow;
  logic        data_addr;
  logic        stop_seen;
  logic        start_seen;
  logic        master_en;
  logic        ten_bit_en;
  logic        gc_en;
  logic [6:0]  own_addr;
  logic [NUM_EV_W-1:0] ev_stat;
  logic [NUM_EV_W-1:0] ev_mask;
  logic [NUM_EV_W-1:0] ev_set;
  logic [15:0] status_word;
  logic        wr_en;
  logic        rd_en;
  logic        tx_start;
  logic        byte_done;
  logic        rx_move;
  logic        addr_hit;
  logic        gc_hit;
  logic        ten_hit;
  logic        coll;

  // ****************************************************************
  // pin synchronisers and condition detection
  // ****************************************************************
  isf_sync u_sync_scl (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (scl_in),
    .dout    (scl_s)
  );
  isf_sync u_sync_sda (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (sda_in),
    .dout    (sda_s)
  );
  isf_cond u_cond (
    .pclk      (pclk),
    .presetn   (presetn),
    .scl       (scl_s),
    .sda       (sda_s),
    .start_det (start_det),
    .stop_det  (stop_det),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall)
  );

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // single-cycle access phase; write lands at the access edge
  always_comb begin
    wr_en = psel & penable & pwrite;
    rd_en = psel & ~penable & ~pwrite;
  end

  // master starts when software loads tx holding while idle
  always_comb begin
    tx_start  = wr_en && paddr == isf_pkg::ADDR_TXDATA &&
                master_en && state == ST_IDLE && !tx_in_progress;
    byte_done = scl_rise && bitcnt == 4'd8;
    rx_move   = byte_done && state == ST_SRX && !first_byte && !ten_pend;
    addr_hit  = first_byte && (shreg[7:1] == own_addr) && !ten_bit_en;
    gc_hit    = first_byte && gc_en && shreg == isf_pkg::GEN_CALL_ADDR;
    ten_hit   = !first_byte && ten_pend && shreg == {1'b0, own_addr};
    // released bit read low while master
    coll      = state == ST_MADDR && bitcnt != 4'd8 && scl_rise &&
                shreg[7] && !sda_s;
  end

  // ****************************************************************
  // byte engine
  // ****************************************************************
  // counts bits on scl rising edges, ninth bit is the ack slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      bitcnt     <= 4'd0;
      shreg      <= 8'h00;
      first_byte <= 1'b0;
      ten_pend   <= 1'b0;
    end else if (stop_det || coll) begin
      state      <= ST_IDLE;
      bitcnt     <= 4'd0;
      ten_pend   <= 1'b0;
    end else if (start_det) begin
      state      <= ST_SRX;
      bitcnt     <= 4'd0;
      first_byte <= 1'b1;
    end else if (tx_start) begin
      state      <= ST_MADDR;
      bitcnt     <= 4'd0;
      shreg      <= pwdata[7:0];
    end else if (scl_rise && state != ST_IDLE) begin
      if (bitcnt == 4'd8) begin
        bitcnt <= 4'd0;
        if (state == ST_MADDR || state == ST_MACK)
          state <= ST_IDLE;
        else if (state == ST_SRX && first_byte) begin
          first_byte <= 1'b0;
          ten_pend   <= ten_bit_en && shreg[7:3] == isf_pkg::TEN_BIT_HDR;
          state      <= (addr_hit || gc_hit ||
                         (ten_bit_en && shreg[7:3] ==
                          isf_pkg::TEN_BIT_HDR)) ? ST_SRX : ST_SKIP;
        end else if (state == ST_SRX)
          ten_pend <= 1'b0;
      end else begin
        bitcnt <= bitcnt + 4'd1;
        if (state == ST_SRX || state == ST_SKIP)
          shreg <= {shreg[6:0], sda_s};
        else
          shreg <= {shreg[6:0], 1'b0};
      end
    end
  end

  // master data and slave ack drive on scl low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_out <= 1'b1;
      sda_oe  <= 1'b0;
      scl_out <= 1'b1;
      scl_oe  <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
      if (coll || state == ST_IDLE) begin
        sda_oe  <= 1'b0;
        sda_out <= 1'b1;
      end else if (scl_fall) begin
        if (state == ST_MADDR && bitcnt != 4'd8) begin
          sda_oe  <= !shreg[7];
          sda_out <= shreg[7];
        end else if (state == ST_SRX && bitcnt == 4'd8) begin
          sda_oe  <= 1'b1;
          sda_out <= 1'b0;
        end else begin
          sda_oe  <= 1'b0;
          sda_out <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // master status flags
  // ****************************************************************
  // progress window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tx_in_progress <= 1'b0;
    else if (tx_start)
      tx_in_progress <= 1'b1;
    else if ((byte_done && state == ST_MADDR) || coll || stop_det)
      tx_in_progress <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ack_status <= 1'b0;
    else if (byte_done && state == ST_MADDR)
      ack_status <= sda_s;
  end

  // sticky collision, set wins, zero clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bus_collision <= 1'b0;
    else if (coll)
      bus_collision <= 1'b1;
    else if (wr_en && paddr == isf_pkg::ADDR_STATUS &&
             !pwdata[isf_pkg::BIT_BUS_COLL])
      bus_collision <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_collision <= 1'b0;
      tx_holding_reg  <= 8'h00;
      tx_full         <= 1'b0;
    end else begin
      if (wr_en && paddr == isf_pkg::ADDR_TXDATA) begin
        if (tx_in_progress || state != ST_IDLE)
          write_collision <= 1'b1;
        else begin
          tx_holding_reg <= pwdata[7:0];
          tx_full        <= 1'b1;
        end
      end else if (wr_en && paddr == isf_pkg::ADDR_STATUS &&
                   !pwdata[isf_pkg::BIT_WR_COLL])
        write_collision <= 1'b0;
      if (byte_done && state == ST_MADDR)
        tx_full <= 1'b0;
    end
  end

  // ****************************************************************
  // slave status flags
  // ****************************************************************
  // address flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_call_seen <= 1'b0;
      ten_bit_match     <= 1'b0;
      data_addr         <= 1'b0;
    end else if (stop_det) begin
      general_call_seen <= 1'b0;
      ten_bit_match     <= 1'b0;
    end else if (byte_done && state == ST_SRX) begin
      if (gc_hit)
        general_call_seen <= 1'b1;
      if (ten_hit)
        ten_bit_match <= 1'b1;
      if (addr_hit || gc_hit || ten_hit)
        data_addr <= 1'b0;
      else if (!first_byte && !ten_pend)
        data_addr <= 1'b1;
    end
  end

  // overflow on move into full holding register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_overflow    <= 1'b0;
      rx_holding_reg <= 8'h00;
      rx_shift_reg   <= 8'h00;
      rx_full        <= 1'b0;
    end else begin
      if (rx_move && !ten_pend) begin
        rx_shift_reg <= shreg;
        if (rx_full)
          rx_overflow <= 1'b1;
        else begin
          rx_holding_reg <= shreg;
          rx_full        <= 1'b1;
        end
      end else if (wr_en && paddr == isf_pkg::ADDR_STATUS &&
                   !pwdata[isf_pkg::BIT_RX_OVF])
        rx_overflow <= 1'b0;
      if (rd_en && paddr == isf_pkg::ADDR_RXDATA)
        rx_full <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_seen  <= 1'b0;
      start_seen <= 1'b0;
    end else if (stop_det) begin
      stop_seen  <= 1'b1;
      start_seen <= 1'b0;
    end else if (start_det) begin
      stop_seen  <= 1'b0;
      start_seen <= 1'b1;
    end
  end

  // ****************************************************************
  // control, interrupt and read-back
  // ****************************************************************
  // control register: enables and own address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_en  <= 1'b0;
      ten_bit_en <= 1'b0;
      gc_en      <= 1'b0;
      own_addr   <= isf_pkg::OWN_ADDR_RST;
      ev_mask    <= '0;
    end else if (wr_en && paddr == isf_pkg::ADDR_CTRL) begin
      master_en  <= pwdata[0];
      ten_bit_en <= pwdata[1];
      gc_en      <= pwdata[2];
      own_addr   <= pwdata[14:8];
    end else if (wr_en && paddr == isf_pkg::ADDR_MASK)
      ev_mask <= pwdata[NUM_EV_W-1:0];
  end

  // events into sticky register, write one clears, set wins
  always_comb begin
    ev_set = '0;
    ev_set[isf_pkg::EV_BUS_COLL] = coll;
    ev_set[isf_pkg::EV_WR_COLL]  = wr_en && paddr == isf_pkg::ADDR_TXDATA
                                   && (tx_in_progress || state != ST_IDLE);
    ev_set[isf_pkg::EV_RX_OVF]   = rx_move && rx_full;
    ev_set[isf_pkg::EV_STOP]     = stop_det;
    ev_set[isf_pkg::EV_RX_BYTE]  = rx_move;
    ev_set[isf_pkg::EV_TX_DONE]  = byte_done && state == ST_MADDR;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_stat <= '0;
      irq     <= 1'b0;
    end else begin
      if (wr_en && paddr == isf_pkg::ADDR_EVENT)
        ev_stat <= (ev_stat & ~pwdata[NUM_EV_W-1:0]) | ev_set;
      else
        ev_stat <= ev_stat | ev_set;
      irq <= |((ev_stat | ev_set) & ev_mask);
    end
  end

  always_comb begin
    status_word = isf_pkg::STATUS_RESET;
    status_word[isf_pkg::BIT_ACK_STATUS] = ack_status;
    status_word[isf_pkg::BIT_TX_PROG]    = tx_in_progress;
    status_word[isf_pkg::BIT_BUS_COLL]   = bus_collision;
    status_word[isf_pkg::BIT_GEN_CALL]   = general_call_seen;
    status_word[isf_pkg::BIT_TEN_BIT]    = ten_bit_match;
    status_word[isf_pkg::BIT_WR_COLL]    = write_collision;
    status_word[isf_pkg::BIT_RX_OVF]     = rx_overflow;
    status_word[isf_pkg::BIT_DATA_ADDR]  = data_addr;
    status_word[isf_pkg::BIT_STOP_SEEN]  = stop_seen;
    status_word[isf_pkg::BIT_START_SEEN] = start_seen;
    status_word[isf_pkg::BIT_RX_FULL]    = rx_full;
    status_word[isf_pkg::BIT_TX_FULL]    = tx_full;
  end

  // read data registered in setup, pready high in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          isf_pkg::ADDR_STATUS: prdata <= {16'h0000, status_word};
          isf_pkg::ADDR_MASK:   prdata <= {26'h0, ev_mask};
          isf_pkg::ADDR_EVENT:  prdata <= {26'h0, ev_stat};
          isf_pkg::ADDR_TXDATA: prdata <= {24'h0, tx_holding_reg};
          isf_pkg::ADDR_RXDATA: prdata <= {24'h0, rx_holding_reg};
          isf_pkg::ADDR_CTRL:   prdata <= {17'h0, own_addr, 5'h0,
                                           gc_en, ten_bit_en, master_en};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

//--- inc/isf_pkg.sv
// Purpose: constants shared by the i2c status-flag block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   status bit positions follow the bus status register layout
package isf_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK   = 8'h04;
  localparam logic [7:0] ADDR_EVENT  = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0c;
  localparam logic [7:0] ADDR_RXDATA = 8'h10;
  localparam logic [7:0] ADDR_CTRL   = 8'h14;
  // ****************************************************************
  // bus status field positions
  // ****************************************************************
  localparam int BIT_ACK_STATUS  = 15;
  localparam int BIT_TX_PROG     = 14;
  localparam int BIT_BUS_COLL    = 10;
  localparam int BIT_GEN_CALL    = 9;
  localparam int BIT_TEN_BIT     = 8;
  localparam int BIT_WR_COLL     = 7;
  localparam int BIT_RX_OVF      = 6;
  localparam int BIT_DATA_ADDR   = 5;
  localparam int BIT_STOP_SEEN   = 4;
  localparam int BIT_START_SEEN  = 3;
  localparam int BIT_RX_FULL     = 1;
  localparam int BIT_TX_FULL     = 0;
  // ****************************************************************
  // event register positions (status for the interrupt)
  // ****************************************************************
  localparam int EV_BUS_COLL = 0;
  localparam int EV_WR_COLL  = 1;
  localparam int EV_RX_OVF   = 2;
  localparam int EV_STOP     = 3;
  localparam int EV_RX_BYTE  = 4;
  localparam int EV_TX_DONE  = 5;
  localparam int NUM_EV      = 6;
  // ****************************************************************
  // values after reset and constants
  // ****************************************************************
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [7:0]  GEN_CALL_ADDR = 8'h00;
  localparam logic [4:0]  TEN_BIT_HDR   = 5'h1e;
  localparam logic [6:0]  OWN_ADDR_RST  = 7'h50;
  localparam logic [9:0]  OWN_ADDR10_RST = 10'h0;
  localparam int          SYNC_STAGES   = 2;
endpackage

//--- logic/isf_sync.sv
// Purpose: two-flop synchroniser for a pin level
// Assumes: input asynchronous to pclk
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module isf_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // level in and out
  input  wire logic din,
  output logic      dout
);
  logic meta;

  // two stages, idle bus level is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

//--- logic/isf_cond.sv
// Purpose: finds start, stop and clock edges on the synchronised bus
// Assumes: scl and sda already synchronised to pclk
// Notes:   outputs are one-cycle pulses
`timescale 1ns/1ps
module isf_cond (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // synchronised bus levels
  input  wire logic scl,
  input  wire logic sda,
  // detected conditions
  output logic      start_det,
  output logic      stop_det,
  output logic      scl_rise,
  output logic      scl_fall
);
  logic scl_q;
  logic sda_q;

  // previous levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // sda moving while scl high marks a start or stop
  always_comb begin
    start_det = scl & scl_q & sda_q & ~sda;
    stop_det  = scl & scl_q & ~sda_q & sda;
    scl_rise  = scl & ~scl_q;
    scl_fall  = ~scl & scl_q;
  end
endmodule

//--- tb/isf_chk.sv
// Purpose: concurrent checks on the status-flag block ports
// Assumes: single pclk domain, presetn asynchronous active low
// Notes:   flag history is rebuilt from apb and pin traffic
`timescale 1ns/1ps
module isf_chk (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // pins and interrupt
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        irq
);
  logic [1:0] seen;
  logic [7:0] idle_cnt;
  logic       last_stop;
  logic       st_rd;
  logic       st_wr;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // status register accesses at the answer edge
  assign st_rd = pready && !pwrite && paddr == isf_pkg::ADDR_STATUS;
  assign st_wr = pready && pwrite && paddr == isf_pkg::ADDR_STATUS;
  // sticky flags seen by software, dropped when written as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= 2'h0;
    end else if (st_wr) begin
      seen <= seen & {pwdata[7], pwdata[6]};
    end else if (st_rd) begin
      seen <= seen | {prdata[7], prdata[6]};
    end
  end
  // last bus condition on the pins and cycles since it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_stop <= 1'b0;
      idle_cnt  <= 8'h0;
    end else if (scl_in && $past(scl_in) && $changed(sda_in)) begin
      last_stop <= sda_in;
      idle_cnt  <= 8'h0;
    end else if (idle_cnt != 8'hff) begin
      idle_cnt <= idle_cnt + 8'h1;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_answer;
    s_setup |=> pready ##1 !pready;
  endproperty
  // ****************************************************************
  // checks
  // ****************************************************************
  AST_RSV_ZERO: assert property (st_rd |-> prdata[13:11] == 3'h0)
    else $error("reserved status bits read nonzero");
  AST_STOP_SEEN: assert property (st_rd && idle_cnt > 8'h0c
    |-> prdata[4] == last_stop) else $error("stop seen bit wrong");
  AST_GC_CLR: assert property (st_rd && last_stop && idle_cnt > 8'h0c
    |-> !prdata[9]) else $error("general call kept after stop");
  AST_TEN_CLR: assert property (st_rd && last_stop && idle_cnt > 8'h0c
    |-> !prdata[8]) else $error("ten bit match kept after stop");
  AST_WCOL_HOLD: assert property (st_rd && seen[1] |-> prdata[7])
    else $error("write collision lost");
  AST_OVF_HOLD: assert property (st_rd && seen[0] |-> prdata[6])
    else $error("overflow lost");
  AST_ANSWER: assert property (p_answer)
    else $error("apb answer not one cycle after setup");
  AST_UNMAPPED: assert property (pready && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access not refused");
  AST_IRQ_OFF: assert property (pready && pwrite
    && paddr == isf_pkg::ADDR_MASK && pwdata[5:0] == 6'h0 |-> ##2 !irq)
    else $error("irq high with all masked");
endmodule
bind isf_top isf_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .pslverr, .scl_in, .sda_in, .irq);

//--- tb/isf_bus_model.sv
// Purpose: far-side i2c party, master of slave frames and acking slave
// Assumes: open-drain sda with pull-up; scl idles high between frames
// Notes:   80 ns bit period, clock only runs inside frames
`timescale 1ns/1ps
module isf_bus_model (
  // device drive
  input  wire logic sda_oe,
  input  wire logic sda_out,
  // wired bus levels
  output logic      scl,
  output logic      sda
);
  logic sda_rel;
  // wired-and: pull-up unless a party pulls low
  assign sda = sda_rel & ~(sda_oe & ~sda_out);
  // lines released at start of run
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end
  // start or repeated start, leaves scl low
  task automatic start();
    sda_rel = 1'b1;
    #20 scl = 1'b1;
    #20 sda_rel = 1'b0;
    #20 scl = 1'b0;
    #20;
  endtask
  // master byte lead-in: scl low before the first bit, no condition
  task automatic lead();
    #20 scl = 1'b0;
    #20;
  endtask
  // stop: sda rises while scl high
  task automatic stop();
    sda_rel = 1'b0;
    #20 scl = 1'b1;
    #20 sda_rel = 1'b1;
    #40;
  endtask
  // eight bits msb first then the ack slot; a one releases sda
  // slave answers ack or nack
  task automatic xfer(input logic [7:0] d, input logic ack);
    logic [8:0] v;
    v = {d, ack};
    for (int i = 8; i >= 0; i--) begin
      sda_rel = v[i];
      #30 scl = 1'b1;
      #30 scl = 1'b0;
      #20;
    end
  endtask
endmodule

//--- tb/i2c_status_flags_tb_top.sv
// Purpose: self-checking bench for the i2c status-flag block
// Assumes: apb answers within 20 cycles; far side is isf_bus_model
// Notes:   masks hide status bits a scenario does not judge
`timescale 1ns/1ps
module i2c_status_flags_tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        scl;
  logic        sda;
  logic        sda_out;
  logic        sda_oe;
  logic        irq;
  logic        err;
  logic [31:0] q;
  int          miscompares;
  int          check_count;
  // device and far side
  isf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .scl_in(scl),
    .scl_out(), .scl_oe(), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq));
  isf_bus_model bus (.sda_oe(sda_oe), .sda_out(sda_out), .scl(scl),
    .sda(sda));
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // compare the bits under mask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input logic [31:0] mask);
    check_count++;
    if ((got & mask) !== (exp & mask)) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(q, e, m);
  endtask
  // registered irq settles two edges after the write
  task automatic irq_is(input logic e);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, {31'h0, e}, 32'h1);
  endtask
  // condition detection lag on the pins
  task automatic settle();
    repeat (12) @(posedge pclk);
  endtask
  // main sequence
  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h0;
    pwdata      = 32'h0;
    miscompares = 0;
    check_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rc(isf_pkg::ADDR_STATUS, 32'h0, 32'hffff);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1, 32'h1);
    // master transmit, nack then ack; busy writes collide
    wr(isf_pkg::ADDR_CTRL, 32'h5001);
    for (int i = 1; i >= 0; i--) begin
      wr(isf_pkg::ADDR_TXDATA, 32'ha5);
      rc(isf_pkg::ADDR_STATUS, 32'h4000, 32'h4000);
      wr(isf_pkg::ADDR_TXDATA, 32'h5a);
      rc(isf_pkg::ADDR_STATUS, 32'h0080, 32'h0080);
      bus.lead();
      bus.xfer(8'hff, i[0]);
      settle();
      rc(isf_pkg::ADDR_STATUS, {16'h0, i[0], 15'h0}, 32'hc000);
      wr(isf_pkg::ADDR_STATUS, 32'h0);
    end
    // far side holds sda low against a released master bit
    wr(isf_pkg::ADDR_TXDATA, 32'ha5);
    bus.xfer(8'h00, 1'b1);
    settle();
    rc(isf_pkg::ADDR_STATUS, 32'h0400, 32'hc400);
    wr(isf_pkg::ADDR_STATUS, 32'h0);
    rc(isf_pkg::ADDR_STATUS, 32'h0, 32'h0400);
    bus.stop();
    // interrupt raised, masked and cleared
    rc(isf_pkg::ADDR_EVENT, 32'h2, 32'h2);
    wr(isf_pkg::ADDR_MASK, 32'h0);
    irq_is(1'b0);
    wr(isf_pkg::ADDR_MASK, 32'h2);
    irq_is(1'b1);
    wr(isf_pkg::ADDR_EVENT, 32'h2);
    irq_is(1'b0);
    rc(isf_pkg::ADDR_EVENT, 32'h0, 32'h2);
    // slave: general call, two bytes unread, then stop
    wr(isf_pkg::ADDR_CTRL, 32'h5006);
    bus.start();
    bus.xfer(8'h00, 1'b1);
    settle();
    rc(isf_pkg::ADDR_STATUS, 32'h0200, 32'h0230);
    bus.xfer(8'h5a, 1'b1);
    settle();
    rc(isf_pkg::ADDR_STATUS, 32'h0020, 32'h0060);
    bus.xfer(8'h33, 1'b1);
    settle();
    rc(isf_pkg::ADDR_STATUS, 32'h0060, 32'h0060);
    rc(isf_pkg::ADDR_RXDATA, 32'h5a, 32'hff);
    bus.stop();
    settle();
    rc(isf_pkg::ADDR_STATUS, 32'h0010, 32'h0310);
    // ten-bit header and own address byte
    bus.start();
    bus.xfer({isf_pkg::TEN_BIT_HDR, 3'h0}, 1'b1);
    bus.xfer(8'h50, 1'b1);
    settle();
    rc(isf_pkg::ADDR_STATUS, 32'h0100, 32'h0110);
    bus.stop();
    settle();
    rc(isf_pkg::ADDR_STATUS, 32'h0010, 32'h0110);
    // zero write clears sticky flags only
    wr(isf_pkg::ADDR_STATUS, 32'h0);
    rc(isf_pkg::ADDR_STATUS, 32'h0010, 32'h04d0);
    conclude();
  end
endmodule
